//--- logic/pci_target_defines.svh
// Constants of the PCI target bus model: offsets, fields, reset values, codes.
// Assumes inclusion by bare name from the design files and the bench.
//
// How it works
// - Runs a 32-bit or 64-bit data path
// - Claims 1 KByte memory and 16-byte I/O
// - Depth and decode span are build parameters
// - One 32-bit I/O data register
// - Any address inside I/O window hits it
// - Byte enables ignored; whole words always moved
// - Retry input retries memory transactions
// - Disconnect with data ends memory transactions
// - Disconnect without data ends memory transactions
// - Reset preloads memory upward from offset zero
// - Locations past the preload image clear
// - Default depth 1024, span 000 to 3FF
`ifndef PCI_TARGET_DEFINES_SVH
`define PCI_TARGET_DEFINES_SVH

`define MEM_DEPTH_DEF 1024
`define MEM_SPAN_DEF 32'h0000_0400
`define IO_MASK 32'hffff_fff0
`define PRELOAD_LINES_DEF 256
`define PRELOAD_BASE_DEF 32'h0000_0000

`define CMD_IO_RD 4'h2
`define CMD_IO_WR 4'h3
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'ha
`define CMD_CFG_WR 4'hb
`define CMD_MEM_RD_MULT 4'hc
`define CMD_MEM_RD_LINE 4'he
`define CMD_MEM_WR_INV 4'hf

`define CFG_ID_IDX 6'h00
`define CFG_CMD_IDX 6'h01
`define CFG_BAR0_IDX 6'h04
`define CFG_BAR1_IDX 6'h05
`define CFG_CMD_IO_BIT 0
`define CFG_CMD_MEM_BIT 1
`define BAR1_IO_FLAG 4'h1

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_XFER_COUNT 8'h08
`define OFS_IO_DATA 8'h0c
`define OFS_BAR0 8'h10
`define OFS_BAR1 8'h14
`define CTRL_WIDE_BIT 0
`define CTRL_RESET 1'b1
`define HSIZE_WORD 3'h2

`endif

//--- logic/pci_target_pkg.sv
// Types shared by the PCI target bus model.
// Assumes nothing beyond the constants header.
package pci_target_pkg;

    typedef enum {ST_IDLE, ST_DATA, ST_STOP, ST_TURN} tgt_state_t;

    typedef enum logic [1:0] {SP_MEM, SP_IO, SP_CFG} space_t;

endpackage : pci_target_pkg

//--- logic/pci_target_mem.sv
// Word memory of the target, flip-flops, preloaded at reset.
// Assumes a power-of-two depth; reads are combinational on two indices.
`timescale 1ns/100ps
`include "pci_target_defines.svh"
module pci_target_mem #(
    parameter int DEPTH = `MEM_DEPTH_DEF,
    parameter int IDX_W = $clog2(`MEM_DEPTH_DEF),
    parameter int PRELOAD_LINES = `PRELOAD_LINES_DEF,
    parameter logic [31:0] PRELOAD_BASE = `PRELOAD_BASE_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [31:0] rd_lo,
    output logic [31:0] rd_hi,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [31:0] wdata_lo,
    input wire logic [31:0] wdata_hi
);

    // Preload image, one line per word
    function automatic logic [31:0] preload_word(input int i);
        preload_word = PRELOAD_BASE + 32'(i);
    endfunction : preload_word

    logic [31:0] mem_reg [DEPTH];
    wire [IDX_W-1:0] rd_idx_hi = rd_idx + IDX_W'(1);
    wire [IDX_W-1:0] wr_idx_hi = wr_idx + IDX_W'(1);

    assign rd_lo = mem_reg[rd_idx];
    assign rd_hi = mem_reg[rd_idx_hi];

    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        wire we_lo = wr_lo && (wr_idx == IDX_W'(g));
        wire we_hi = wr_hi && (wr_idx_hi == IDX_W'(g));
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mem_reg[g] <= (g < PRELOAD_LINES) ? preload_word(g) : 32'h0;
            end else if (we_lo) begin
                mem_reg[g] <= wdata_lo;
            end else if (we_hi) begin
                mem_reg[g] <= wdata_hi;
            end
        end
    end

    AST_PRELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> (mem_reg[0] == preload_word(0)) &&
            (mem_reg[DEPTH-1] == ((DEPTH - 1 < PRELOAD_LINES) ? preload_word(DEPTH - 1) : 32'h0)))
        else $error("Memory not preloaded at reset");

endmodule : pci_target_mem

//--- logic/pci_target_bus_model.sv
// PCI target agent with memory window, I/O register and config space.
// Assumes PCI inputs synchronous to hclk and an AHB-Lite master for control.
`timescale 1ns/100ps
`include "pci_target_defines.svh"
module pci_target_bus_model
    import pci_target_pkg::*;
#(
    parameter bit DATA64 = 1'b1,
    parameter int MEM_DEPTH = `MEM_DEPTH_DEF,
    parameter logic [31:0] MEM_SPAN = `MEM_SPAN_DEF,
    parameter int PRELOAD_LINES = `PRELOAD_LINES_DEF,
    parameter logic [31:0] PRELOAD_BASE = `PRELOAD_BASE_DEF,
    parameter logic [31:0] ID_CODE = 32'h0001_0002 // Arbitrary value
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic frame_n_in,
    input wire logic irdy_n_in,
    input wire logic idsel_in,
    input wire logic req64_n_in,
    input wire logic [7:0] cbe_n_in,
    input wire logic [63:0] ad_in,
    output logic [63:0] ad_out,
    output logic ad_lo_oe,
    output logic ad_hi_oe,
    output logic devsel_n_out,
    output logic devsel_n_oe,
    output logic trdy_n_out,
    output logic trdy_n_oe,
    output logic stop_n_out,
    output logic stop_n_oe,
    output logic ack64_n_out,
    output logic ack64_n_oe,
    input wire logic retry_in,
    input wire logic disconnect_with_data_in,
    input wire logic disconnect_no_data_in
);

    localparam int IDX_W = $clog2(MEM_DEPTH);
    localparam int SPAN_W = $clog2(MEM_SPAN);

    tgt_state_t state_reg, state_next;
    space_t space_reg, space_next;
    logic frame_q_reg;
    logic write_reg;
    logic wide_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [5:0] cfg_sel_reg;
    logic devsel_n_reg, devsel_n_next;
    logic trdy_n_reg, trdy_n_next;
    logic stop_n_reg, stop_n_next;
    logic ack64_n_reg, ack64_n_next;
    logic ctl_oe_reg, ctl_oe_next;
    logic ad_lo_oe_reg, ad_lo_oe_next;
    logic ad_hi_oe_reg, ad_hi_oe_next;
    logic [63:0] ad_out_reg;
    logic [31:0] io_data_reg;
    logic [31:0] bar0_reg;
    logic [31:0] bar1_reg;
    logic [1:0] cmd_reg;
    logic [31:0] xfer_count_reg;
    logic ctrl_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic [31:0] mem_lo;
    logic [31:0] mem_hi;

    // Address phase decode
    wire addr_phase = (state_reg == ST_IDLE) && !frame_n_in && frame_q_reg;
    wire [3:0] cmd = cbe_n_in[3:0];
    wire cmd_wr = cmd[0];
    wire cmd_mem = (cmd == `CMD_MEM_RD) || (cmd == `CMD_MEM_RD_MULT) ||
        (cmd == `CMD_MEM_RD_LINE) || (cmd == `CMD_MEM_WR) || (cmd == `CMD_MEM_WR_INV);
    wire cmd_io = (cmd == `CMD_IO_RD) || (cmd == `CMD_IO_WR);
    wire cmd_cfg = (cmd == `CMD_CFG_RD) || (cmd == `CMD_CFG_WR);
    wire [31:0] span_mask = ~(MEM_SPAN - 32'h1);
    wire mem_hit = addr_phase && cmd_mem && cmd_reg[`CFG_CMD_MEM_BIT] &&
        ((ad_in[31:0] & span_mask) == bar0_reg);
    wire io_hit = addr_phase && cmd_io && cmd_reg[`CFG_CMD_IO_BIT] &&
        ((ad_in[31:0] & `IO_MASK) == (bar1_reg & `IO_MASK));
    // Config hit relies on idsel being tied to an address line
    wire cfg_hit = addr_phase && cmd_cfg && idsel_in && (ad_in[1:0] == 2'b00);
    wire any_hit = mem_hit || io_hit || cfg_hit;
    wire go64 = mem_hit && DATA64 && ctrl_reg && !req64_n_in;
    wire space_t space_dec = mem_hit ? SP_MEM : (io_hit ? SP_IO : SP_CFG);

    // Data phase bookkeeping
    wire xfer = (state_reg == ST_DATA) && !irdy_n_in && !trdy_n_reg;
    wire wide_next = addr_phase ? go64 : wide_reg;
    wire [IDX_W-1:0] idx_step = wide_reg ? IDX_W'(2) : IDX_W'(1);
    wire [IDX_W-1:0] idx_dec = IDX_W'(ad_in[SPAN_W-1:2]);
    wire [IDX_W-1:0] idx_next = addr_phase ? idx_dec :
        ((xfer && space_reg == SP_MEM) ? idx_reg + idx_step : idx_reg);
    wire [5:0] cfg_sel_next = addr_phase ? ad_in[7:2] : cfg_sel_reg;
    assign space_next = addr_phase ? space_dec : space_reg;

    // Read data for the next data phase
    wire [31:0] cfg_rd = (cfg_sel_next == `CFG_ID_IDX) ? ID_CODE :
        (cfg_sel_next == `CFG_CMD_IDX) ? {30'h0, cmd_reg} :
        (cfg_sel_next == `CFG_BAR0_IDX) ? bar0_reg :
        (cfg_sel_next == `CFG_BAR1_IDX) ? bar1_reg : 32'h0;
    wire [31:0] rd_lo = (space_next == SP_MEM) ? mem_lo :
        ((space_next == SP_IO) ? io_data_reg : cfg_rd);
    wire [31:0] rd_hi = wide_next ? mem_hi : 32'h0;

    // Writes move whole words whatever the byte enables say
    wire mem_wr = xfer && write_reg && (space_reg == SP_MEM);
    wire io_wr = xfer && write_reg && (space_reg == SP_IO);
    wire cfg_wr = xfer && write_reg && (space_reg == SP_CFG);

    pci_target_mem #(
        .DEPTH(MEM_DEPTH),
        .IDX_W(IDX_W),
        .PRELOAD_LINES(PRELOAD_LINES),
        .PRELOAD_BASE(PRELOAD_BASE)
    ) u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .rd_idx(idx_next),
        .rd_lo(mem_lo),
        .rd_hi(mem_hi),
        .wr_idx(idx_reg),
        .wr_lo(mem_wr),
        .wr_hi(mem_wr && wide_reg),
        .wdata_lo(ad_in[31:0]),
        .wdata_hi(ad_in[63:32])
    );

    // Target handshake sequencing
    always_comb begin
        state_next = state_reg;
        devsel_n_next = devsel_n_reg;
        trdy_n_next = trdy_n_reg;
        stop_n_next = stop_n_reg;
        ack64_n_next = ack64_n_reg;
        ctl_oe_next = ctl_oe_reg;
        ad_lo_oe_next = ad_lo_oe_reg;
        ad_hi_oe_next = ad_hi_oe_reg;
        case (state_reg)
            ST_IDLE: begin
                if (any_hit) begin
                    state_next = ST_DATA;
                    devsel_n_next = 1'b0;
                    ctl_oe_next = 1'b1;
                    ack64_n_next = !go64;
                    ad_lo_oe_next = !cmd_wr;
                    ad_hi_oe_next = go64 && !cmd_wr;
                    if (mem_hit && retry_in) begin
                        state_next = ST_STOP;
                        stop_n_next = 1'b0;
                    end else begin
                        trdy_n_next = 1'b0;
                        stop_n_next = !(mem_hit && disconnect_with_data_in);
                    end
                end
            end
            ST_DATA: begin
                if (xfer && frame_n_in) begin
                    state_next = ST_TURN;
                    devsel_n_next = 1'b1;
                    trdy_n_next = 1'b1;
                    stop_n_next = 1'b1;
                    ack64_n_next = 1'b1;
                    ad_lo_oe_next = 1'b0;
                    ad_hi_oe_next = 1'b0;
                end else if (xfer && !stop_n_reg) begin
                    state_next = ST_STOP;
                    trdy_n_next = 1'b1;
                end else if (xfer && space_reg == SP_MEM && disconnect_no_data_in) begin
                    state_next = ST_STOP;
                    trdy_n_next = 1'b1;
                    stop_n_next = 1'b0;
                end
            end
            ST_STOP: begin
                if (frame_n_in) begin
                    state_next = ST_TURN;
                    devsel_n_next = 1'b1;
                    trdy_n_next = 1'b1;
                    stop_n_next = 1'b1;
                    ack64_n_next = 1'b1;
                    ad_lo_oe_next = 1'b0;
                    ad_hi_oe_next = 1'b0;
                end
            end
            ST_TURN: begin
                state_next = ST_IDLE;
                ctl_oe_next = 1'b0;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            space_reg <= SP_MEM;
            frame_q_reg <= 1'b1;
            write_reg <= 1'b0;
            wide_reg <= 1'b0;
            idx_reg <= '0;
            cfg_sel_reg <= 6'h0;
            devsel_n_reg <= 1'b1;
            trdy_n_reg <= 1'b1;
            stop_n_reg <= 1'b1;
            ack64_n_reg <= 1'b1;
            ctl_oe_reg <= 1'b0;
            ad_lo_oe_reg <= 1'b0;
            ad_hi_oe_reg <= 1'b0;
            ad_out_reg <= 64'h0;
        end else begin
            state_reg <= state_next;
            space_reg <= space_next;
            frame_q_reg <= frame_n_in;
            write_reg <= addr_phase ? cmd_wr : write_reg;
            wide_reg <= wide_next;
            idx_reg <= idx_next;
            cfg_sel_reg <= cfg_sel_next;
            devsel_n_reg <= devsel_n_next;
            trdy_n_reg <= trdy_n_next;
            stop_n_reg <= stop_n_next;
            ack64_n_reg <= ack64_n_next;
            ctl_oe_reg <= ctl_oe_next;
            ad_lo_oe_reg <= ad_lo_oe_next;
            ad_hi_oe_reg <= ad_hi_oe_next;
            ad_out_reg <= {rd_hi, rd_lo};
        end
    end

    // I/O register, config space and phase counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_data_reg <= 32'h0;
            bar0_reg <= 32'h0;
            bar1_reg <= {28'h0, `BAR1_IO_FLAG};
            cmd_reg <= 2'h0;
            xfer_count_reg <= 32'h0;
        end else begin
            io_data_reg <= io_wr ? ad_in[31:0] : io_data_reg;
            if (cfg_wr && cfg_sel_reg == `CFG_CMD_IDX) cmd_reg <= ad_in[1:0];
            if (cfg_wr && cfg_sel_reg == `CFG_BAR0_IDX) bar0_reg <= ad_in[31:0] & span_mask;
            if (cfg_wr && cfg_sel_reg == `CFG_BAR1_IDX) bar1_reg <= {ad_in[31:4], `BAR1_IO_FLAG};
            xfer_count_reg <= xfer ? xfer_count_reg + 32'h1 : xfer_count_reg;
        end
    end

    // AHB-Lite slave, zero wait states
    wire ahb_take = hsel && htrans[1] && hready;
    wire ahb_wr_take = ahb_take && hwrite && (hsize == `HSIZE_WORD);
    wire ctrl_wr = wr_pend_reg && (wr_addr_reg == `OFS_CTRL);
    wire ctrl_view = ctrl_wr ? hwdata[`CTRL_WIDE_BIT] : ctrl_reg;
    wire [31:0] ahb_rd = (haddr[7:0] == `OFS_CTRL) ? {31'h0, ctrl_view} :
        (haddr[7:0] == `OFS_STATUS) ? {30'h0, wide_reg, state_reg != ST_IDLE} :
        (haddr[7:0] == `OFS_XFER_COUNT) ? xfer_count_reg :
        (haddr[7:0] == `OFS_IO_DATA) ? io_data_reg :
        (haddr[7:0] == `OFS_BAR0) ? bar0_reg :
        (haddr[7:0] == `OFS_BAR1) ? bar1_reg : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            ctrl_reg <= `CTRL_RESET;
            hrdata_reg <= 32'h0;
            hreadyout_reg <= 1'b0;
        end else begin
            wr_pend_reg <= ahb_wr_take;
            wr_addr_reg <= ahb_wr_take ? haddr[7:0] : wr_addr_reg;
            ctrl_reg <= ctrl_view;
            hrdata_reg <= (ahb_take && !hwrite) ? ahb_rd : hrdata_reg;
            hreadyout_reg <= 1'b1;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign ad_out = ad_out_reg;
    assign ad_lo_oe = ad_lo_oe_reg;
    assign ad_hi_oe = ad_hi_oe_reg;
    assign devsel_n_out = devsel_n_reg;
    assign trdy_n_out = trdy_n_reg;
    assign stop_n_out = stop_n_reg;
    assign ack64_n_out = ack64_n_reg;
    assign devsel_n_oe = ctl_oe_reg;
    assign trdy_n_oe = ctl_oe_reg;
    assign stop_n_oe = ctl_oe_reg;
    assign ack64_n_oe = ctl_oe_reg;

    AST_RETRY: assert property (@(posedge hclk) disable iff (!hresetn)
        mem_hit && retry_in |=> !stop_n_out && trdy_n_out && !devsel_n_out ##1 trdy_n_out)
        else $error("Retry not signalled");
    AST_DISC_DATA: assert property (@(posedge hclk) disable iff (!hresetn)
        mem_hit && !retry_in && disconnect_with_data_in |=> !stop_n_out && !trdy_n_out)
        else $error("Disconnect with data not signalled");
    AST_DISC_NODATA: assert property (@(posedge hclk) disable iff (!hresetn)
        xfer && !frame_n_in && stop_n_out && space_reg == SP_MEM && disconnect_no_data_in
        |=> trdy_n_out && !stop_n_out)
        else $error("Disconnect without data not signalled");
    AST_NORMAL: assert property (@(posedge hclk) disable iff (!hresetn)
        any_hit && !retry_in && !disconnect_with_data_in |=> !trdy_n_out && stop_n_out)
        else $error("Normal completion not offered");
    AST_BURST_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        xfer && space_reg == SP_MEM |=> idx_reg == IDX_W'($past(idx_reg) + $past(idx_step)))
        else $error("Burst index did not advance");
    AST_IO_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        xfer && space_reg == SP_IO && !write_reg |-> ad_out[31:0] == io_data_reg)
        else $error("I/O read data wrong");
    AST_IO_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        io_wr |=> io_data_reg == $past(ad_in[31:0]))
        else $error("I/O write not whole word");
    AST_WIDE_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
        go64 |=> !ack64_n_out && (ad_hi_oe == !write_reg))
        else $error("64-bit acknowledge missing");
    AST_NO_CLAIM: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && cmd_mem && ((ad_in[31:0] & span_mask) != bar0_reg) && !idsel_in
        |=> devsel_n_out ##1 devsel_n_out)
        else $error("Claimed outside memory window");
    AST_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == ST_TURN |=> !ctl_oe_reg && !ad_lo_oe_reg && state_reg == ST_IDLE)
        else $error("Bus not released");

    COV_RETRY: cover property (@(posedge hclk) disable iff (!hresetn) mem_hit && retry_in);
    COV_BURST: cover property (@(posedge hclk) disable iff (!hresetn) xfer ##1 xfer ##1 xfer);
    COV_WIDE: cover property (@(posedge hclk) disable iff (!hresetn) go64 ##[1:8] xfer);
    COV_IO: cover property (@(posedge hclk) disable iff (!hresetn) io_wr);

endmodule : pci_target_bus_model

//--- testbench/pci_master_model.sv
// PCI initiator model that drives the target's bus inputs.
// Assumes the bench resolves AD from both parties, pulled high when free.
`timescale 1ns/100ps
module pci_master_model (
    input wire logic hclk,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic ack64_n,
    input wire logic [63:0] ad_wire,
    output logic frame_n,
    output logic irdy_n,
    output logic req64_n,
    output logic [7:0] cbe_n,
    output logic [63:0] m_ad,
    output logic m_oe
);
    int cnt;
    logic saw_stop;
    logic saw_wide;
    logic [31:0] rd_q[$];

    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        req64_n = 1'b1;
        cbe_n = 8'hff;
        m_ad = 64'h0;
        m_oe = 1'b0;
    end

    // One transaction; gives up when no target claims it
    task automatic run(input logic [3:0] cmd, input logic [31:0] addr, input int n,
        input logic wide, input logic [31:0] wbase);
        logic xfer;
        logic rd;
        logic [31:0] widx;
        cnt = 0;
        saw_stop = 1'b0;
        saw_wide = 1'b0;
        rd_q.delete();
        rd = !cmd[0];
        widx = 32'h0;
        frame_n <= 1'b0;
        req64_n <= !wide;
        cbe_n <= {4'h0, cmd};
        m_ad <= {32'h0, addr};
        m_oe <= 1'b1;
        @(posedge hclk);
        frame_n <= (n == 1);
        irdy_n <= 1'b0;
        cbe_n <= 8'h5a;
        m_oe <= !rd;
        m_ad <= {wbase + 32'h1, wbase};
        for (int k = 0; k < 40; k++) begin
            @(posedge hclk);
            xfer = !irdy_n && !trdy_n;
            if (!stop_n) saw_stop = 1'b1;
            if (xfer) begin
                cnt++;
                if (!ack64_n) saw_wide = 1'b1;
                if (rd) rd_q.push_back(ad_wire[31:0]);
                if (rd && !ack64_n) rd_q.push_back(ad_wire[63:32]);
                widx = widx + (ack64_n ? 32'h1 : 32'h2);
                m_ad <= {wbase + widx + 32'h1, wbase + widx};
            end
            if (frame_n && (xfer || !stop_n || (devsel_n && k > 4))) break;
            if (!stop_n || (devsel_n && k > 4) || (xfer && cnt == n - 1)) frame_n <= 1'b1;
        end
        irdy_n <= 1'b1;
        req64_n <= 1'b1;
        m_oe <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : run
endmodule : pci_master_model

//--- testbench/tb_pci_target_bus_model.sv
// Self-checking bench for the PCI target bus model.
// Assumes the master model and the design sources are compiled first.
`timescale 1ns/100ps
`include "pci_target_defines.svh"
module tb_pci_target_bus_model
    import pci_target_pkg::*;
;
    localparam logic [31:0] BAR0_V = 32'h0000_4000;
    localparam logic [31:0] BAR1_V = 32'h0000_2001;
    localparam logic [31:0] PBASE = 32'h0000_1000;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic retry_in, disconnect_with_data_in, disconnect_no_data_in;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic frame_n_in, irdy_n_in, req64_n_in, m_oe;
    logic [7:0] cbe_n_in;
    logic [63:0] ad_out, m_ad;
    logic ad_lo_oe, ad_hi_oe, devsel_n_out, devsel_n_oe, trdy_n_out, trdy_n_oe;
    logic stop_n_out, stop_n_oe, ack64_n_out, ack64_n_oe;
    wire logic hready;
    wire logic idsel_in;
    wire logic [63:0] ad_in;
    int bad_count, check_count, i;

    assign hready = hreadyout;
    assign ad_in[31:0] = ad_lo_oe ? ad_out[31:0] : (m_oe ? m_ad[31:0] : 32'hffff_ffff);
    assign ad_in[63:32] = ad_hi_oe ? ad_out[63:32] : (m_oe ? m_ad[63:32] : 32'hffff_ffff);
    assign idsel_in = ad_in[24];

    pci_target_bus_model #(.PRELOAD_LINES(200), .PRELOAD_BASE(PBASE)) dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .frame_n_in, .irdy_n_in, .idsel_in, .req64_n_in,
        .cbe_n_in, .ad_in, .ad_out, .ad_lo_oe, .ad_hi_oe, .devsel_n_out, .devsel_n_oe,
        .trdy_n_out, .trdy_n_oe, .stop_n_out, .stop_n_oe, .ack64_n_out, .ack64_n_oe,
        .retry_in, .disconnect_with_data_in, .disconnect_no_data_in);

    pci_master_model mst_u (
        .hclk, .devsel_n(devsel_n_out), .trdy_n(trdy_n_out), .stop_n(stop_n_out),
        .ack64_n(ack64_n_out), .ad_wire(ad_in), .frame_n(frame_n_in), .irdy_n(irdy_n_in),
        .req64_n(req64_n_in), .cbe_n(cbe_n_in), .m_ad, .m_oe);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // One single AHB-Lite word transfer
    task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= `HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb({24'h0, a}, 1'b0, 32'h0, v);
        check(v, exp);
    endtask : rd_chk

    task automatic cfg_wr(input logic [5:0] idx, input logic [31:0] d);
        mst_u.run(`CMD_CFG_WR, {24'h01_0000, idx, 2'b00}, 1, 1'b0, d);
        check(32'(mst_u.cnt), 32'h1);
    endtask : cfg_wr

    task automatic seq_chk(input logic [31:0] first, input int n);
        check(32'(mst_u.rd_q.size()), 32'(n));
        for (int j = 0; j < n && j < mst_u.rd_q.size(); j++) begin
            check(mst_u.rd_q[j], first + 32'(j));
        end
    endtask : seq_chk

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        repeat (5000) @(posedge hclk);
        bad_count++;
        $display("BAD at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {retry_in, disconnect_with_data_in, disconnect_no_data_in} = 3'b000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(`OFS_CTRL, 32'h1);
        rd_chk(`OFS_BAR1, 32'h1);
        rd_chk(8'h40, 32'h0);
        cfg_wr(`CFG_BAR0_IDX, BAR0_V);
        cfg_wr(`CFG_BAR1_IDX, BAR1_V);
        cfg_wr(`CFG_CMD_IDX, 32'h3);
        rd_chk(`OFS_BAR0, BAR0_V);
        mst_u.run(`CMD_CFG_RD, {24'h01_0000, `CFG_BAR0_IDX, 2'b00}, 1, 1'b0, 32'h0);
        check(mst_u.rd_q[0], BAR0_V);
        $display("Test registers and configuration done");
        mst_u.run(`CMD_MEM_RD, BAR0_V, 4, 1'b0, 32'h0);
        seq_chk(PBASE, 4);
        check({25'h0, hresp, ad_lo_oe, ad_hi_oe, devsel_n_oe, trdy_n_oe, stop_n_oe, ack64_n_oe},
            32'h0);
        mst_u.run(`CMD_MEM_RD_MULT, BAR0_V + 32'h31c, 2, 1'b0, 32'h0);
        check(mst_u.rd_q[0], PBASE + 32'd199);
        check(mst_u.rd_q[1], 32'h0);
        mst_u.run(`CMD_MEM_WR, BAR0_V + 32'h3f4, 3, 1'b0, 32'hc0de_0000);
        mst_u.run(`CMD_MEM_RD, BAR0_V + 32'h3f4, 3, 1'b0, 32'h0);
        seq_chk(32'hc0de_0000, 3);
        mst_u.run(`CMD_MEM_RD, BAR0_V + 32'h400, 1, 1'b0, 32'h0);
        check(32'(mst_u.cnt), 32'h0);
        $display("Test memory window done");
        mst_u.run(`CMD_MEM_WR_INV, BAR0_V + 32'h10, 2, 1'b1, 32'hbeef_0000);
        mst_u.run(`CMD_MEM_RD_LINE, BAR0_V + 32'h10, 2, 1'b1, 32'h0);
        check({31'h0, mst_u.saw_wide}, 32'h1);
        rd_chk(`OFS_STATUS, 32'h2);
        seq_chk(32'hbeef_0000, 4);
        ahb({24'h0, `OFS_CTRL}, 1'b1, 32'h0, v);
        rd_chk(`OFS_CTRL, 32'h0);
        mst_u.run(`CMD_MEM_RD, BAR0_V + 32'h10, 2, 1'b1, 32'h0);
        check({31'h0, mst_u.saw_wide}, 32'h0);
        seq_chk(32'hbeef_0000, 2);
        $display("Test data path width done");
        mst_u.run(`CMD_IO_WR, 32'h0000_2007, 1, 1'b0, 32'h1234_5678);
        mst_u.run(`CMD_IO_RD, 32'h0000_200c, 1, 1'b0, 32'h0);
        check(mst_u.rd_q[0], 32'h1234_5678);
        rd_chk(`OFS_IO_DATA, 32'h1234_5678);
        mst_u.run(`CMD_IO_RD, 32'h0000_2010, 1, 1'b0, 32'h0);
        check(32'(mst_u.cnt), 32'h0);
        $display("Test I/O register done");
        for (i = 0; i < 3; i++) begin
            retry_in <= (i == 0);
            disconnect_with_data_in <= (i == 1);
            disconnect_no_data_in <= (i == 2);
            mst_u.run(`CMD_MEM_RD, BAR0_V, 3, 1'b0, 32'h0);
            check(32'(mst_u.cnt), (i == 0) ? 32'h0 : 32'h1);
            check({31'h0, mst_u.saw_stop}, 32'h1);
        end
        retry_in <= 1'b1;
        disconnect_with_data_in <= 1'b1;
        mst_u.run(`CMD_IO_RD, 32'h0000_2000, 1, 1'b0, 32'h0);
        check({31'h0, mst_u.saw_stop}, 32'h0);
        check(32'(mst_u.cnt), 32'h1);
        {retry_in, disconnect_with_data_in, disconnect_no_data_in} <= 3'b000;
        mst_u.run(`CMD_MEM_RD, BAR0_V, 3, 1'b0, 32'h0);
        check({31'h0, mst_u.saw_stop}, 32'h0);
        seq_chk(PBASE, 3);
        rd_chk(`OFS_XFER_COUNT, 32'd30);
        $display("Test terminations done");
        results();
    end
endmodule : tb_pci_target_bus_model
